// *** rtl/mcir_map.vh ***
`ifndef MCIR_MAP_VH
`define MCIR_MAP_VH
// Register offsets (4-bit address space)
`define MCIR_ADDR_PRSR 4'h0
`define MCIR_ADDR_MASK 4'h1
`define MCIR_ADDR_STAT 4'h2
`define MCIR_ADDR_CTLA 4'h3
`define MCIR_ADDR_CTLB 4'h4
`define MCIR_ADDR_EXTS 4'h5
`define MCIR_ADDR_IEN 4'h6
`define MCIR_ADDR_ICLR 4'h7
// Reset value of every register
`define MCIR_RST8 8'h00
// Field positions
`define MCIR_SA_HI 7
`define MCIR_SA_LO 4
`define MCIR_ST_HI 3
`define MCIR_ST_LO 0
`define MCIR_B_PU 7
`define MCIR_B_SE 6
`define MCIR_B_RP 6
`define MCIR_B_RI 5
`define MCIR_B_RM 5
`define MCIR_B_CL 4
`define MCIR_B_EI 3
`define MCIR_B_ZI 2
`define MCIR_B_DI 1
`define MCIR_B_CI 0
// Control A fields
`define MCIR_B_MOE 7
`define MCIR_B_VC 3
`define MCIR_B_SWA 2
// Control B fields (own register)
`define MCIR_B_HDM 5
`define MCIR_B_SDM 4
`define MCIR_TES_HI 1
`define MCIR_TES_LO 0
// Special write value and prescaler ratio limits
`define MCIR_FORCE_UPD 8'hff
`define MCIR_ST_MAX 4'hf
`define MCIR_ST_MIN 4'h0
`endif

// *** rtl/mcir_regs.v ***
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "mcir_map.vh"
module mcir_regs (
  input wire clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire cpu_irq_masked,
  input wire pwm_update_evt,
  input wire speed_err_evt,
  input wire ratio_up_evt,
  input wire ratio_down_evt,
  input wire curr_limit_evt,
  input wire estop_evt,
  input wire zero_cross_evt,
  input wire demag_end_evt,
  input wire commut_evt,
  input wire [5:0] phase_drive,
  output reg [5:0] phase_outputs,
  output wire phase_out_enable,
  output wire [3:0] timer_prescale_ratio,
  output wire [3:0] curr_mode_rate_sel,
  output reg timer_shift_right,
  output reg timer_shift_left,
  output reg pwm_force_update,
  output wire volt_curr_sel,
  output wire auto_switch_sel,
  output wire irq_req,
  output wire irq
);

  reg [7:0] prsr_q;
  reg [7:0] mask_q;
  reg [7:0] stat_q;
  reg [7:0] ctla_q;
  reg [7:0] ctlb_q;
  reg [7:0] ext_q;
  reg [7:0] ien_q;
  reg [7:0] stat_d;
  reg [7:0] ext_d;
  reg [3:0] st_d;
  reg sr_q;
  wire wr_stat;
  wire force_upd;
  wire ratio_flags_plain;
  wire [7:0] stat_evt;
  wire [7:0] ext_evt;
  wire [7:0] gate;

  assign curr_mode_rate_sel = prsr_q[`MCIR_SA_HI:`MCIR_SA_LO];
  assign timer_prescale_ratio = prsr_q[`MCIR_ST_HI:`MCIR_ST_LO];
  assign phase_out_enable = ctla_q[`MCIR_B_MOE];
  assign volt_curr_sel = ctla_q[`MCIR_B_VC];
  assign auto_switch_sel = ctla_q[`MCIR_B_SWA];

  // Speed sensor mode counts as any nonzero sensor select code
  assign ratio_flags_plain = auto_switch_sel |
    (ctlb_q[`MCIR_TES_HI:`MCIR_TES_LO] != 2'b00);
  assign wr_stat = wr_en && (addr == `MCIR_ADDR_STAT);
  assign force_upd = wr_stat && (wdata == `MCIR_FORCE_UPD);

  // Hardware events into the status layout; ratio events only in plain-flag modes
  assign stat_evt = {pwm_update_evt | force_upd,
                     ratio_up_evt & ratio_flags_plain,
                     ratio_down_evt & ratio_flags_plain,
                     curr_limit_evt & ~volt_curr_sel,
                     estop_evt, zero_cross_evt, demag_end_evt, commut_evt};

  // Speed error has no status bit here; it lives in the extra event register
  assign ext_evt = stat_evt | {1'b0, speed_err_evt, 6'h00};

  // Mask gating; ratio flags in switched mode are action requests, not interrupts
  assign gate = {mask_q[`MCIR_B_PU],
                 mask_q[`MCIR_B_RI] & ratio_flags_plain,
                 mask_q[`MCIR_B_RI] & ratio_flags_plain,
                 mask_q[`MCIR_B_CL], mask_q[`MCIR_B_EI], mask_q[`MCIR_B_ZI],
                 mask_q[`MCIR_B_DI] & (ctlb_q[`MCIR_B_HDM] | ctlb_q[`MCIR_B_SDM]),
                 mask_q[`MCIR_B_CI]};

  assign irq_req = (|(stat_q & gate) | (ext_q[`MCIR_B_SE] & mask_q[`MCIR_B_SE]))
                   & ~cpu_irq_masked;
  assign irq = |(ext_q & ien_q);

  always @* begin
    stat_d = stat_q;
    if (wr_stat && !force_upd) begin
      // Write 0 clears, write 1 keeps (autoswitched: 1 never sets)
      stat_d = stat_q & wdata;
      if (!ratio_flags_plain) begin
        // Switched mode: ratio bits are written directly as requests
        stat_d[`MCIR_B_RP] = wdata[`MCIR_B_RP];
        stat_d[`MCIR_B_RM] = wdata[`MCIR_B_RM];
      end
    end
    // Ratio requests are consumed at the commutation that applies them
    if (!ratio_flags_plain && commut_evt && !wr_stat) begin
      stat_d[`MCIR_B_RP] = 1'b0;
      stat_d[`MCIR_B_RM] = 1'b0;
    end
    // Set wins over clear
    stat_d = stat_d | stat_evt;
  end

  always @* begin
    st_d = prsr_q[`MCIR_ST_HI:`MCIR_ST_LO];
    timer_shift_right = 1'b0;
    timer_shift_left = 1'b0;
    if (!ratio_flags_plain && commut_evt &&
        (stat_q[`MCIR_B_RP] ^ stat_q[`MCIR_B_RM])) begin
      // Both set at once is ignored, as neither would be honoured
      if (stat_q[`MCIR_B_RP] && st_d != `MCIR_ST_MAX) begin
        st_d = st_d + 4'h1;
        timer_shift_right = 1'b1;
      end else if (stat_q[`MCIR_B_RM] && st_d != `MCIR_ST_MIN) begin
        st_d = st_d - 4'h1;
        timer_shift_left = 1'b1;
      end
    end else if (ratio_flags_plain) begin
      // Saturate rather than wrap, a wrapped prescaler would jump speed range
      if (ratio_up_evt && !ratio_down_evt && st_d != `MCIR_ST_MAX)
        st_d = st_d + 4'h1;
      else if (ratio_down_evt && !ratio_up_evt && st_d != `MCIR_ST_MIN)
        st_d = st_d - 4'h1;
    end
  end

  always @* begin
    ext_d = ext_q | ext_evt;
    if (wr_en && addr == `MCIR_ADDR_ICLR)
      ext_d = (ext_q & ~wdata) | ext_evt;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prsr_q <= `MCIR_RST8;
      mask_q <= `MCIR_RST8;
      stat_q <= `MCIR_RST8;
      ctla_q <= `MCIR_RST8;
      ctlb_q <= `MCIR_RST8;
      ext_q <= `MCIR_RST8;
      ien_q <= `MCIR_RST8;
      rdata <= `MCIR_RST8;
      phase_outputs <= 6'h00;
      pwm_force_update <= 1'b0;
      sr_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      ext_q <= ext_d;
      pwm_force_update <= force_upd;
      sr_q <= rd_en;
      if (wr_en && addr == `MCIR_ADDR_PRSR)
        // A software write wins over a same-cycle ratio step
        prsr_q <= wdata;
      else
        prsr_q[`MCIR_ST_HI:`MCIR_ST_LO] <= st_d;
      if (wr_en && addr == `MCIR_ADDR_MASK)
        mask_q <= wdata;
      if (wr_en && addr == `MCIR_ADDR_CTLA)
        ctla_q <= wdata;
      if (wr_en && addr == `MCIR_ADDR_CTLB)
        ctlb_q <= wdata;
      if (wr_en && addr == `MCIR_ADDR_IEN)
        ien_q <= wdata;
      // Outputs held low (reset state) while disabled
      phase_outputs <= ctla_q[`MCIR_B_MOE] ? phase_drive : 6'h00;
      if (rd_en) begin
        case (addr)
          `MCIR_ADDR_PRSR: rdata <= prsr_q;
          `MCIR_ADDR_MASK: rdata <= mask_q;
          `MCIR_ADDR_STAT: rdata <= stat_q;
          `MCIR_ADDR_CTLA: rdata <= ctla_q;
          `MCIR_ADDR_CTLB: rdata <= ctlb_q;
          `MCIR_ADDR_EXTS: rdata <= ext_q;
          `MCIR_ADDR_IEN: rdata <= ien_q;
          default: rdata <= `MCIR_RST8;
        endcase
      end else if (sr_q) begin
        rdata <= `MCIR_RST8;
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/mcir_regs_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module mcir_chk (
  input wire logic clk, rst_n, wr_en, cpu_irq_masked, ratio_up_evt, ratio_down_evt,
  input wire logic commut_evt, phase_out_enable, timer_shift_right, timer_shift_left,
  input wire logic pwm_force_update, irq_req,
  input wire logic [3:0] addr, timer_prescale_ratio, curr_mode_rate_sel,
  input wire logic [7:0] wdata,
  input wire logic [5:0] phase_drive, phase_outputs
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_force_wr; wr_en && addr == 4'h2 && wdata == 8'hff; endsequence
  sequence s_quiet; !commut_evt && !ratio_up_evt && !ratio_down_evt; endsequence
  property p_force; s_force_wr |=> pwm_force_update; endproperty
  a_force: assert property (p_force) else $error("force");
  property p_prsr; s_quiet ##0 (wr_en && addr == 4'h0) |=>
    {curr_mode_rate_sel, timer_prescale_ratio} == $past(wdata); endproperty
  a_prsr: assert property (p_prsr) else $error("prescaler");
  property p_hold; s_quiet ##0 !(wr_en && addr == 4'h0) |=> $stable(timer_prescale_ratio);
  endproperty
  a_hold: assert property (p_hold) else $error("ratio moved");
  property p_moe; wr_en && addr == 4'h3 |=> phase_out_enable == $past(wdata[7]); endproperty
  a_moe: assert property (p_moe) else $error("enable bit");
  // Reset state of the phases is low; enable gates the delayed drive
  property p_phase; phase_outputs == ($past(phase_out_enable) ? $past(phase_drive) : 6'h0);
  endproperty
  a_phase: assert property (p_phase) else $error("phases");
  property p_shr; timer_shift_right |-> commut_evt && !timer_shift_left; endproperty
  a_shr: assert property (p_shr) else $error("shift right");
  property p_shl; timer_shift_left |-> commut_evt && !timer_shift_right; endproperty
  a_shl: assert property (p_shl) else $error("shift left");
  property p_gate; cpu_irq_masked |-> !irq_req; endproperty
  a_gate: assert property (p_gate) else $error("masked request");
endmodule
bind mcir_regs mcir_chk u_chk (.clk, .rst_n, .wr_en, .cpu_irq_masked, .ratio_up_evt,
  .ratio_down_evt, .commut_evt, .phase_out_enable, .timer_shift_right, .timer_shift_left,
  .pwm_force_update, .irq_req, .addr, .timer_prescale_ratio, .curr_mode_rate_sel, .wdata,
  .phase_drive, .phase_outputs);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, cpu_irq_masked = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0;
  logic [8:0] ev = 0;
  logic [5:0] phase_drive = 0;
  logic [31:0] sd = 32'h460ca6ea;
  wire [7:0] rdata;
  wire [5:0] phase_outputs;
  wire [3:0] timer_prescale_ratio;
  wire phase_out_enable, timer_shift_right, timer_shift_left, pwm_force_update, irq_req, irq;
  int fail_count = 0, checks = 0, cyc = 0, r;
  mcir_regs uut (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .cpu_irq_masked,
    .pwm_update_evt(ev[8]), .speed_err_evt(ev[7]), .ratio_up_evt(ev[6]), .ratio_down_evt(ev[5]),
    .curr_limit_evt(ev[4]), .estop_evt(ev[3]), .zero_cross_evt(ev[2]), .demag_end_evt(ev[1]),
    .commut_evt(ev[0]), .phase_drive, .phase_outputs, .phase_out_enable, .timer_prescale_ratio,
    .curr_mode_rate_sel(), .timer_shift_right, .timer_shift_left, .pwm_force_update,
    .volt_curr_sel(), .auto_switch_sel(), .irq_req, .irq);
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      final_report();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function automatic logic [7:0] sbit(input int k);
    return (k == 8) ? 8'h80 : 8'h01 << k;
  endfunction
  task automatic chk(input logic [7:0] v, input logic [7:0] e);
    checks++;
    if (v !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1;
    @(posedge clk);
    wr_en <= 0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1;
    @(posedge clk);
    rd_en <= 0;
    #1 chk(rdata, e);
  endtask
  task automatic pulse(input logic [8:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 0;
    #1;
  endtask
  task automatic com(input logic [7:0] sh, input logic [7:0] tp);
    @(posedge clk);
    ev <= 9'h001;
    #1 chk({6'h0, timer_shift_left, timer_shift_right}, sh);
    @(posedge clk);
    ev <= 0;
    #1 chk({4'h0, timer_prescale_ratio}, tp);
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    for (int a = 0; a < 9; a++) rd(a[3:0], 8'h00);
    for (int i = 0; i < 20; i++) begin
      sd = xs(sd);
      wr(4'h0, sd[7:0]);
      rd(4'h0, sd[7:0]);
      wr(4'h1, sd[15:8]);
      rd(4'h1, sd[15:8]);
      wr(4'h3, sd[23:16]);
      phase_drive <= sd[29:24];
      rd(4'h3, sd[23:16]);
      chk({2'h0, phase_outputs}, sd[23] ? {2'h0, sd[29:24]} : 8'h00);
    end
    $display("register test done");
    wr(4'h1, 8'hff);
    wr(4'h3, 8'h04);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h37);
    r = 7;
    for (int k = 0; k < 9; k++) if (k != 7) begin
      wr(4'h2, 8'h00);
      pulse(9'h001 << k);
      r = r + (k == 6) - (k == 5);
      chk({7'h0, irq_req}, {7'h0, k != 1});
      chk({4'h0, timer_prescale_ratio}, r[7:0]);
      rd(4'h2, sbit(k));
      wr(4'h2, ~sbit(k));
      rd(4'h2, 8'h00);
    end
    wr(4'h3, 8'h0c);
    wr(4'h2, 8'h7e);
    rd(4'h2, 8'h00);
    pulse(9'h010);
    rd(4'h2, 8'h00);
    cpu_irq_masked <= 1;
    pulse(9'h008);
    chk({7'h0, irq_req}, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h2, 8'hff);
    chk({7'h0, pwm_force_update}, 8'h01);
    rd(4'h2, 8'h80);
    $display("event test done");
    // Switched mode: ratio bits only act at the next commutation
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h05);
    wr(4'h2, 8'h9f);
    wr(4'h2, 8'hbf);
    com(8'h02, 8'h04);
    wr(4'h2, 8'hdf);
    com(8'h01, 8'h05);
    com(8'h00, 8'h05);
    // Speed sensor select nonzero: ratio bits become plain flags again
    wr(4'h4, 8'h01);
    wr(4'h2, 8'h00);
    pulse(9'h040);
    chk({4'h0, timer_prescale_ratio}, 8'h06);
    rd(4'h2, 8'h40);
    $display("switched test done");
    wr(4'h7, 8'hff);
    pulse(9'h080);
    rd(4'h5, 8'h40);
    wr(4'h6, 8'h40);
    chk({7'h0, irq}, 8'h01);
    wr(4'h6, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(4'h6, 8'h40);
    wr(4'h7, 8'h40);
    chk({7'h0, irq}, 8'h00);
    $display("interrupt test done");
    final_report();
  end
endmodule
`default_nettype wire
